/* File: core/pin_arb_pkg.sv */
// constants and types for the shared-pin feature arbiter
// assumes one 40 MHz clock and undervoltage lockout as active-low reset
// How it works
// - three features on one pin are arbitrated, never all acted on together
// - winner comes from the ordered pair of first and second arrivals
// - restart enable first keeps holding, later blanking request is discarded
// - blanking first is aborted when a restart enable request follows
// - brownout after blanking waits for blanking end and fault clearance
// - brownout first keeps holding, later restart enable is ignored
// - restart enable or brownout arriving first wins over later requests
// - fault cleared before blanking end delays brownout by 20 ms
// - accepted restart enable forces non-switching restart mode, gate off
// - blanking counts 256 pin cycles then signals completion
// - pin below brownout reference raises brownout, non-switching mode
package pin_arb_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned BUFFER_MS     = 20;
   localparam int unsigned BUFFER_CYC    = CLK_HZ / 1000 * BUFFER_MS;
   localparam int unsigned BLANK_COUNT   = 256;
   localparam int unsigned BUF_W         = 20;
   localparam logic [8:0]  BLANK_DONE    = 9'h100;
   localparam logic [8:0]  BLANK_RESET   = 9'h000;

   // ---------------------------------------------------------------
   // arbitration states
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      ST_IDLE    = 5'h01,
      ST_RESTART = 5'h02,
      ST_BLANK   = 5'h04,
      ST_BROWN   = 5'h08,
      ST_BUFFER  = 5'h10
   } arb_state_t;

endpackage : pin_arb_pkg

/* File: core/pin_feature_arbiter.sv */
// shared multi_function_pin feature arbiter
// assumes comparator and blanking inputs arrive from the analog side asynchronously
`timescale 1ns/100ps
module pin_feature_arbiter
   import pin_arb_pkg::*;
#(
   parameter int unsigned BUFFER_CYCLES = BUFFER_CYC
)
(
   input  wire logic CLK_I,
   input  wire logic RST_N_I,
   input  wire logic RESTART_REQ_I,
   input  wire logic BLANK_REQ_I,
   input  wire logic BLANK_EDGE_I,
   input  wire logic OVERLOAD_I,
   input  wire logic BROWNOUT_I,
   output logic      RESTART_MODE_O,
   output logic      BROWNOUT_MODE_O,
   output logic      BLANK_ACTIVE_O,
   output logic      BLANK_DONE_O,
   output logic      GATE_OFF_O
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   logic       edge_prev_q;
   logic       restart_s;
   logic       blank_s;
   logic       edge_s;
   logic       ovl_s;
   logic       brown_s;
   logic       edge_rise;

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         sync1_q     <= 5'h00;
         sync2_q     <= 5'h00;
         edge_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q     <= {BROWNOUT_I, OVERLOAD_I, BLANK_EDGE_I, BLANK_REQ_I, RESTART_REQ_I};
         sync2_q     <= sync1_q;
         edge_prev_q <= sync2_q[2];
      end
   end

   assign restart_s = sync2_q[0];
   assign blank_s   = sync2_q[1];
   assign edge_s    = sync2_q[2];
   assign ovl_s     = sync2_q[3];
   assign brown_s   = sync2_q[4];
   // each charge to the upper threshold counts one cycle
   assign edge_rise = edge_s & ~edge_prev_q;

   // ---------------------------------------------------------------
   // arbitration state
   // ---------------------------------------------------------------
   arb_state_t      state_q;
   arb_state_t      state_d;
   logic [8:0]      cnt_q;
   logic [8:0]      cnt_d;
   logic [BUF_W-1:0] buf_q;
   logic [BUF_W-1:0] buf_d;
   logic            brown_pend_q;
   logic            brown_pend_d;
   logic            ovl_gone_q;
   logic            ovl_gone_d;

   always_comb
   begin
      state_d      = state_q;
      cnt_d        = cnt_q;
      buf_d        = buf_q;
      brown_pend_d = brown_pend_q;
      ovl_gone_d   = ovl_gone_q;
      unique case (state_q)
         ST_IDLE:
         begin
            // simultaneous arrivals: restart beats brownout beats blanking
            if (restart_s)
               state_d = ST_RESTART;
            else if (brown_s)
               state_d = ST_BROWN;
            else if (blank_s)
            begin
               state_d      = ST_BLANK;
               cnt_d        = BLANK_RESET;
               brown_pend_d = 1'b0;
               ovl_gone_d   = 1'b0;
            end
         end
         ST_RESTART:
         begin
            // later blanking or brownout is discarded while held
            if (!restart_s)
               state_d = ST_IDLE;
         end
         ST_BROWN:
         begin
            // restart enable ignored until brownout clears
            if (!brown_s)
               state_d = ST_IDLE;
         end
         ST_BLANK:
         begin
            if (brown_s)
               brown_pend_d = 1'b1;
            if (!ovl_s)
               ovl_gone_d = 1'b1;
            if (edge_rise && cnt_q != BLANK_DONE)
               cnt_d = cnt_q + 9'h001;
            if (restart_s)
               state_d = ST_RESTART;
            else if (cnt_q == BLANK_DONE || !blank_s)
            begin
               // brownout acts only after blanking ends and the fault is gone
               if ((brown_pend_q || brown_s) && !ovl_s)
               begin
                  if (ovl_gone_q)
                  begin
                     state_d = ST_BUFFER;
                     buf_d   = BUF_W'(BUFFER_CYCLES - 1);
                  end
                  else
                     state_d = ST_BROWN;
               end
               else if (!blank_s)
                  state_d = ST_IDLE;
            end
         end
         ST_BUFFER:
         begin
            if (restart_s && !brown_s)
               state_d = ST_RESTART;
            else if (!brown_s)
               state_d = ST_IDLE;
            else if (buf_q == '0)
               state_d = ST_BROWN;
            else
               buf_d = buf_q - BUF_W'(1);
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_q      <= ST_IDLE;
         cnt_q        <= BLANK_RESET;
         buf_q        <= '0;
         brown_pend_q <= 1'b0;
         ovl_gone_q   <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         cnt_q        <= cnt_d;
         buf_q        <= buf_d;
         brown_pend_q <= brown_pend_d;
         ovl_gone_q   <= ovl_gone_d;
      end
   end

   // ---------------------------------------------------------------
   // verdict outputs
   // ---------------------------------------------------------------
   assign RESTART_MODE_O  = (state_q == ST_RESTART);
   assign BROWNOUT_MODE_O = (state_q == ST_BROWN);
   assign BLANK_ACTIVE_O  = (state_q == ST_BLANK);
   assign BLANK_DONE_O    = (state_q == ST_BLANK) && (cnt_q == BLANK_DONE);
   assign GATE_OFF_O      = RESTART_MODE_O | BROWNOUT_MODE_O;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_blank_held;
      state_q == ST_BLANK;
   endsequence

   a_restart_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      state_q == ST_RESTART && restart_s |=> state_q == ST_RESTART)
      else $error("restart mode lost while request held");

   a_blank_abort: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      s_blank_held ##0 restart_s |=> state_q == ST_RESTART)
      else $error("blanking not aborted by restart");

   a_brown_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      state_q == ST_BROWN && brown_s |=> state_q == ST_BROWN)
      else $error("brownout left while request held");

   a_blank_no_brown: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      s_blank_held ##0 (cnt_q != BLANK_DONE && blank_s) |=> state_q != ST_BROWN)
      else $error("brownout acted during blanking");

   a_idle_priority: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      state_q == ST_IDLE && restart_s |=> state_q == ST_RESTART)
      else $error("restart not taken from idle");

   // buffer may be left early only when brownout withdraws, never into brownout
   a_buffer_wait: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $rose(state_q == ST_BUFFER) |-> (state_q != ST_BROWN)[*8])
      else $error("buffer time cut short");

   a_buffer_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $rose(state_q == ST_BUFFER) |-> buf_q == BUF_W'(BUFFER_CYCLES - 1))
      else $error("buffer timer not loaded with full span");

   a_buffer_early: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      state_q == ST_BUFFER && buf_q != '0 |=> state_q != ST_BROWN)
      else $error("brownout before buffer timer expired");

   a_blank_count: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      s_blank_held ##0 (edge_rise && cnt_q != BLANK_DONE) |=> cnt_q == $past(cnt_q) + 9'h001)
      else $error("blanking count missed a pin cycle");

   a_done_holds: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      BLANK_DONE_O && blank_s && ovl_s && !restart_s |=> BLANK_DONE_O)
      else $error("completion dropped while overload persists");

   a_gate_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      RESTART_MODE_O |-> GATE_OFF_O)
      else $error("gate running in restart mode");

endmodule : pin_feature_arbiter

/* File: tb/prot_model.sv */
// protection side model: built-in blanking delay, then pin charge cycles
// assumes tb drives overload level; edge half period set per run
`timescale 1ns/100ps
module prot_model
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       overload_i,
   input  wire logic [2:0] half_i,
   output logic            blank_req_o,
   output logic            blank_edge_o
);
   int unsigned wait_q;
   int unsigned ph_q;
   int unsigned cnt_q;

   // counter stays at 256 so a finished count never re-arms before lockout
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         blank_req_o  <= 1'b0;
         blank_edge_o <= 1'b0;
         wait_q       <= 0;
         ph_q         <= 0;
         cnt_q        <= 0;
      end
      else if (!blank_req_o)
      begin
         wait_q <= (overload_i && cnt_q == 0) ? wait_q + 1 : 0;
         if (wait_q == 3)
            blank_req_o <= 1'b1;
      end
      else if (cnt_q == 256)
      begin
         // request stands while the fault persists after the count
         if (!overload_i)
            blank_req_o <= 1'b0;
      end
      else if (ph_q + 1 >= half_i)
      begin
         ph_q         <= 0;
         blank_edge_o <= ~blank_edge_o;
         cnt_q        <= cnt_q + blank_edge_o;
      end
      else
         ph_q <= ph_q + 1;
   end
endmodule : prot_model

/* File: tb/pin_feature_arbiter_tb_top.sv */
// self-checking bench for the shared pin feature arbiter
// assumes short buffer parameter; outputs checked 4 cycles after a change
`timescale 1ns/100ps
module pin_feature_arbiter_tb_top;
   import pin_arb_pkg::*;
   localparam int unsigned BUF = 16;
   logic       clk, rst_n, rreq, ovl, brown, breq, bedge, rm, bm, ba, done, gate;
   logic [2:0] half;
   logic [4:0] exp_q[$];
   int         fails, cmp_count, seed, k;
   event       sample_ev;

   pin_feature_arbiter #(.BUFFER_CYCLES(BUF)) u_pin_feature_arbiter (
      .CLK_I(clk), .RST_N_I(rst_n), .RESTART_REQ_I(rreq), .BLANK_REQ_I(breq),
      .BLANK_EDGE_I(bedge), .OVERLOAD_I(ovl), .BROWNOUT_I(brown), .RESTART_MODE_O(rm),
      .BROWNOUT_MODE_O(bm), .BLANK_ACTIVE_O(ba), .BLANK_DONE_O(done), .GATE_OFF_O(gate));
   prot_model u_prot_model (.clk_i(clk), .rst_n_i(rst_n), .overload_i(ovl), .half_i(half),
      .blank_req_o(breq), .blank_edge_o(bedge));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic note(input logic [4:0] e);
      exp_q.push_back(e);
      ->sample_ev;
   endtask : note
   task automatic check(input logic [4:0] seen, input logic [4:0] want);
      cmp_count++;
      if (seen !== want)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic lockout();
      rst_n = 1'b0;
      rreq  = 1'b0;
      ovl   = 1'b0;
      brown = 1'b0;
      half  = 3'(2 + ($unsigned($random(seed)) % 4));
      cyc(2);
      rst_n = 1'b1;
      cyc(2);
   endtask : lockout
   task automatic stop_test();
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // clock, monitor, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   forever
   begin
      @(sample_ev);
      check({rm, bm, ba, done, gate}, exp_q.pop_front());
   end
   // covers every scenario plus the longest slow charge cycle run
   initial
   begin
      #(25 * 60000);
      fails++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // scenarios: vector is restart, brownout, blanking, done, gate off
   // ---------------------------------------------------------------
   initial
   begin
      seed  = 32'h84781550;
      rst_n = 1'b0;
      rreq  = 1'b0;
      ovl   = 1'b0;
      brown = 1'b0;
      half  = 3'h2;
      cyc(12);
      rst_n = 1'b1;
      cyc(1);
      note(5'h00);
      rreq = 1'b1;
      cyc(4);
      note(5'h11);
      ovl = 1'b1;
      cyc(12);
      note(5'h11);
      rst_n = 1'b0;
      cyc(1);
      note(5'h00);
      lockout();
      ovl = 1'b1;
      cyc(10);
      note(5'h04);
      rreq = 1'b1;
      cyc(4);
      note(5'h11);
      lockout();
      brown = 1'b1;
      cyc(4);
      note(5'h09);
      rreq = 1'b1;
      cyc(4);
      note(5'h09);
      ovl = 1'b1;
      cyc(12);
      note(5'h09);
      lockout();
      rreq = 1'b1;
      cyc(4);
      brown = 1'b1;
      cyc(4);
      note(5'h11);
      // fault held: 255th rise seen, then the 256th completes the count
      lockout();
      ovl = 1'b1;
      cyc(10 + 509 * half);
      note(5'h04);
      cyc(2 * half);
      note(5'h06);
      ovl = 1'b0;
      cyc(6);
      note(5'h00);
      lockout();
      ovl = 1'b1;
      cyc(10);
      brown = 1'b1;
      cyc(4);
      note(5'h04);
      ovl = 1'b0;
      cyc(4);
      note(5'h04);
      for (k = 0; k < 5000 && breq; k++)
         cyc(1);
      cyc(6);
      note(5'h00);
      cyc(BUF + 4);
      note(5'h09);
      cyc(4);
      stop_test();
   end
endmodule : pin_feature_arbiter_tb_top
